// ==== hw/ext_bus_pkg.sv ====
// Package with the constants, types and state of the external bus master.
package ext_bus_pkg;
    localparam int ADDR_W = 28;
    localparam int DATA_W = 32;
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_LINE = 2'h3;
    localparam logic [1:0] PORT_8    = 2'h1;
    localparam logic [1:0] PORT_16   = 2'h2;
    localparam logic [1:0] PORT_32   = 2'h0;
    localparam logic [4:0] MAX_BEATS = 5'h10;
    localparam logic [4:0] ONE_BEAT  = 5'h01;

    typedef enum logic [1:0] {
        IDLE,
        START,
        WAIT_ACK
    } bus_state_t;

    // One request from the core: a whole operand.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [1:0]        opSize;
        logic [1:0]        portSize;
        logic              read;
        logic [1:0]        xferType;
        logic              code;
        logic              supervisor;
        logic              dram;
        logic [127:0]      wdata;
    } bus_req_t;

    // Pins that the master drives toward the slave.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [1:0]        xferType;
        logic [1:0]        xferSize;
        logic              accessAttr;
        logic              readNotWrite;
        logic              xferStart_n;
        logic [DATA_W-1:0] dataOut;
        logic              dataOe;
    } bus_pins_t;

    typedef struct packed {
        bus_state_t        state;
        bus_req_t          req;
        bus_pins_t         pins;
        logic [4:0]        beatsLeft;
        logic [127:0]      rdata;
        logic              done;
        logic              error;
        logic              asyncBeat;
    } bus_state_reg_t;
endpackage : ext_bus_pkg

// ==== hw/ack_sync.sv ====
// Two flip-flop synchroniser for the asynchronous acknowledge.
`timescale 1ns/1ps
`default_nettype none
module ack_sync (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic asyncIn_n,
    output var  logic syncOut
);
    logic meta;
    // The first stage samples on the falling edge, so an acknowledge given before the middle of
    // the second clock is seen at the start of the third; only the second stage reads it.
    always_ff @(negedge clk) begin
        if (sys_rst) begin
            meta <= 1'b0;
        end else begin
            meta <= ~asyncIn_n;
        end
    end

    // The second stage hands the acknowledge to the rising-edge logic a half clock later.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            syncOut <= 1'b0;
        end else begin
            syncOut <= meta;
        end
    end
endmodule : ack_sync
`default_nettype wire

// ==== hw/ext_bus_master.sv ====
// External bus master with burst-inhibited beats and synchronous or asynchronous acknowledge.
// Summary of operation
// - First clock drives address, control, start strobe.
// - Size shows byte 1, word 2, constant.
// - Second clock drops start, shows privilege.
// - Read samples acknowledge, latches lane, waits.
// - Each beat but the last increments address, restarts strobe.
// - Transfer takes one to sixteen beats.
// - Write data driven from second clock.
// - Data bus released after each write beat.
// - Asynchronous acknowledge ends non-DRAM transfers.
// - Async acknowledge synchronised; error aborts transfer.
// - Async read data latched on synced edge.
// - Async write data held until recognised.
// - Early async acknowledge recognised by third clock.
// - Size shows beat width, never line.
// - No burst-inhibited transfers to DRAM.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_master
    import ext_bus_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire ext_bus_pkg::bus_req_t         req,
    input  wire logic                          reqValid,
    output logic                               reqReady,
    output var  logic [127:0]                  rdata,
    output var  logic                          done,
    output var  logic                          error,
    output var  ext_bus_pkg::bus_pins_t        pins,
    input  wire logic [ext_bus_pkg::DATA_W-1:0] dataIn,
    input  wire logic                          sync_ack_n,
    input  wire logic                          async_ack_n,
    input  wire logic                          xfer_error_n
);
    import ext_bus_pkg::*;

    bus_state_reg_t r;
    bus_state_reg_t next_r;
    logic asyncAck;
    logic beatAck;
    logic [1:0] beatSize;
    logic [4:0] beatCount;
    logic [DATA_W-1:0] beatData;

    ack_sync u_sync (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .asyncIn_n (async_ack_n),
        .syncOut   (asyncAck)
    );

    assign reqReady = (r.state == IDLE);

    // Beat width is the port width when the operand is wider, else the operand size.
    always_comb begin
        beatSize  = SIZE_BYTE;
        beatCount = ONE_BEAT;
        unique case (req.portSize)
            PORT_8: begin
                beatSize  = SIZE_BYTE;
                beatCount = (req.opSize == SIZE_LINE) ? MAX_BEATS : (req.opSize == SIZE_LONG) ? 5'h04 :
                            (req.opSize == SIZE_WORD) ? 5'h02 : ONE_BEAT;
            end
            PORT_16: begin
                beatSize  = (req.opSize == SIZE_BYTE) ? SIZE_BYTE : SIZE_WORD;
                beatCount = (req.opSize == SIZE_LINE) ? 5'h08 : (req.opSize == SIZE_LONG) ? 5'h02 : ONE_BEAT;
            end
            default: begin
                beatSize  = (req.opSize == SIZE_LINE) ? SIZE_LONG : req.opSize;
                beatCount = (req.opSize == SIZE_LINE) ? 5'h04 : ONE_BEAT;
            end
        endcase
    end

    // A beat ends on the first sample of either acknowledge; async is not taken for DRAM.
    assign beatAck = (r.state == WAIT_ACK) && (~sync_ack_n || (asyncAck && !r.req.dram));

    // Next write word comes from the top of the remaining operand, placed on the active lanes.
    assign beatData = r.req.wdata[127 -: DATA_W];

    always_comb begin
        next_r = r;
        next_r.done  = 1'b0;
        next_r.error = 1'b0;
        unique case (r.state)
            IDLE: begin
                next_r.pins.dataOe = 1'b0;
                if (reqValid && !req.dram) begin
                    next_r.state = START;
                    next_r.req   = req;
                    next_r.beatsLeft = beatCount;
                    next_r.pins.addr = req.addr;
                    next_r.pins.xferType = req.xferType;
                    next_r.pins.xferSize = beatSize;
                    next_r.pins.readNotWrite = req.read;
                    next_r.pins.accessAttr = req.code;
                    next_r.pins.xferStart_n = 1'b0;
                end
            end
            START: begin
                next_r.state = WAIT_ACK;
                next_r.pins.xferStart_n = 1'b0 ^ 1'b1;
                next_r.pins.accessAttr  = r.req.supervisor;
                if (!r.req.read) begin
                    next_r.pins.dataOut = beatData;
                    next_r.pins.dataOe  = 1'b1;
                end
            end
            WAIT_ACK: begin
                if (!xfer_error_n) begin
                    next_r.state = IDLE;
                    next_r.error = 1'b1;
                    next_r.done  = 1'b1;
                    next_r.pins.dataOe = 1'b0;
                end else if (beatAck) begin
                    if (r.req.read) begin
                        unique case (r.pins.xferSize)
                            SIZE_BYTE: next_r.rdata = {r.rdata[119:0], dataIn[31:24]};
                            SIZE_WORD: next_r.rdata = {r.rdata[111:0], dataIn[31:16]};
                            default:   next_r.rdata = {r.rdata[95:0], dataIn};
                        endcase
                    end
                    unique case (r.pins.xferSize)
                        SIZE_BYTE: next_r.req.wdata = {r.req.wdata[119:0], 8'h00};
                        SIZE_WORD: next_r.req.wdata = {r.req.wdata[111:0], 16'h0000};
                        default:   next_r.req.wdata = {r.req.wdata[95:0], 32'h00000000};
                    endcase
                    next_r.beatsLeft = r.beatsLeft - ONE_BEAT;
                    next_r.pins.dataOe = 1'b0;
                    if (r.beatsLeft == ONE_BEAT) begin
                        next_r.state = IDLE;
                        next_r.done  = 1'b1;
                    end else begin
                        next_r.state = START;
                        next_r.pins.xferStart_n = 1'b0;
                        next_r.pins.accessAttr = r.req.code;
                        unique case (r.pins.xferSize)
                            SIZE_BYTE: next_r.pins.addr = r.pins.addr + 28'h0000001;
                            SIZE_WORD: next_r.pins.addr = r.pins.addr + 28'h0000002;
                            default:   next_r.pins.addr = r.pins.addr + 28'h0000004;
                        endcase
                    end
                end
            end
            default: next_r.state = IDLE;
        endcase
    end

    // Whole state in one register; reset parks the bus with start negated.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r <= '0;
            r.state <= IDLE;
            r.pins.xferStart_n <= 1'b1;
            r.pins.readNotWrite <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign pins  = r.pins;
    assign rdata = r.rdata;
    assign done  = r.done;
    assign error = r.error;

    chk_start_one_clock: assert property (@(posedge clk) disable iff (sys_rst)
        !pins.xferStart_n |=> pins.xferStart_n) else $error("start strobe held two clocks");
    chk_size_never_line: assert property (@(posedge clk) disable iff (sys_rst)
        r.state != IDLE |-> pins.xferSize != SIZE_LINE) else $error("line size shown");
    chk_size_stable: assert property (@(posedge clk) disable iff (sys_rst)
        r.state == WAIT_ACK && beatAck && !done |=> $stable(pins.xferSize) && $stable(pins.readNotWrite))
        else $error("size or direction changed between beats");
    chk_write_release: assert property (@(posedge clk) disable iff (sys_rst)
        beatAck && xfer_error_n |=> !pins.dataOe) else $error("data bus not released");
    chk_write_drive: assert property (@(posedge clk) disable iff (sys_rst)
        r.state == START && !r.req.read |=> pins.dataOe) else $error("write data not driven");
    chk_error_ends: assert property (@(posedge clk) disable iff (sys_rst)
        r.state == WAIT_ACK && !xfer_error_n |=> error && r.state == IDLE) else $error("error did not end");
    chk_idle_ignore: assert property (@(posedge clk) disable iff (sys_rst)
        r.state == IDLE && !reqValid |=> r.state == IDLE && !done) else $error("idle acknowledge taken");
    chk_beat_count: assert property (@(posedge clk) disable iff (sys_rst)
        r.beatsLeft <= MAX_BEATS) else $error("beat count too large");
    chk_dir_first: assert property (@(posedge clk) disable iff (sys_rst)
        r.state == IDLE && reqValid && !req.dram |=> !pins.xferStart_n && pins.readNotWrite == $past(req.read))
        else $error("first clock wrong");

    cov_sync_read: cover property (@(posedge clk) r.req.read && beatAck && !sync_ack_n && done == 1'b0);
    cov_async_write: cover property (@(posedge clk) !r.req.read && beatAck && asyncAck);
    cov_error: cover property (@(posedge clk) error);
endmodule : ext_bus_master
`default_nettype wire

// ==== sim/ext_slave_model.sv ====
// Behavioural slave that answers the bus master with programmable wait states.
`timescale 1ns/1ps
`default_nettype none
module ext_slave_model
    import ext_bus_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire ext_bus_pkg::bus_pins_t pins,
    input  wire logic                   done,
    input  wire logic                   asyncMode,
    input  wire logic [3:0]             waits,
    output logic [31:0]                 dataIn,
    output logic                        sync_ack_n,
    output logic                        async_ack_n,
    output logic [127:0]                capWords
);
    import ext_bus_pkg::*;
    logic        busy;
    logic [3:0]  left;
    logic [31:0] lastData;
    logic        ackOn;
    logic        ackPrev;
    logic [15:0] busData;
    // The answer stands once the wait count has run out after a start strobe.
    assign ackOn = busy && (left == 4'h0);
    assign sync_ack_n = !(ackOn && !asyncMode);
    // The async answer comes in the second clock, not tied active, so one wait state follows.
    assign async_ack_n = !(ackOn && asyncMode);
    // Released lanes show the inverse of the last value, so a late latch reads garbage.
    assign dataIn = ackOn ? {4{pins.addr[7:0] ^ 8'h3c}} : ~lastData;
    // A released write bus shows the inverse of the master's word, so a late capture is caught.
    assign busData = pins.dataOe ? pins.dataOut[31:16] : ~pins.dataOut[31:16];
    // An async answer is held until the master reports the end, since its recognition is hidden;
    // an end by error releases the slave as well, so a cut transfer leaves no answer behind.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
            left <= 4'h0;
            lastData <= 32'h0;
            capWords <= 128'h0;
            ackPrev <= 1'b0;
        end else begin
            if (!pins.xferStart_n) begin
                busy <= 1'b1;
                left <= waits;
            end else if (done) begin
                busy <= 1'b0;
            end else if (busy && left != 4'h0) begin
                left <= left - 4'h1;
            end else if (ackOn && !asyncMode) begin
                busy <= 1'b0;
            end
            ackPrev <= ackOn;
            if (ackOn) begin
                lastData <= dataIn;
            end
            // Each write answer captures once at its first edge, which for async is still in the second clock.
            if (ackOn && !ackPrev && !pins.readNotWrite) begin
                capWords <= {capWords[111:0], busData};
            end
        end
    end
endmodule : ext_slave_model
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the external bus master against a behavioural slave.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ext_bus_pkg::*;
    logic clk, sys_rst, reqValid, reqReady, done, error, asyncMode, errN, sawStart;
    logic sync_ack_n, async_ack_n;
    logic [127:0] rdata, capWords;
    logic [31:0] dataIn;
    logic [27:0] expAddr, step;
    logic [3:0] waits;
    logic [1:0] expSize;
    bus_req_t req;
    bus_pins_t pins;
    int mismatches, total_checks, beats, lat;
    ext_bus_master dut (.clk(clk), .sys_rst(sys_rst), .req(req), .reqValid(reqValid), .reqReady(reqReady),
        .rdata(rdata), .done(done), .error(error), .pins(pins), .dataIn(dataIn), .sync_ack_n(sync_ack_n),
        .async_ack_n(async_ack_n), .xfer_error_n(errN));
    ext_slave_model slave (.clk(clk), .sys_rst(sys_rst), .pins(pins), .done(done), .asyncMode(asyncMode),
        .waits(waits), .dataIn(dataIn), .sync_ack_n(sync_ack_n), .async_ack_n(async_ack_n), .capWords(capWords));
    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check
    // Every beat is checked where its start strobe shows, and its second clock right after.
    always begin
        @(posedge clk);
        #1;
        if (sawStart) check({pins.xferStart_n, pins.accessAttr}, {1'b1, req.supervisor}, "second clock");
        sawStart = !pins.xferStart_n;
        if (sawStart) begin
            beats++;
            check({pins.addr, pins.xferSize, pins.readNotWrite, pins.xferType, pins.accessAttr},
                {expAddr, expSize, req.read, req.xferType, req.code}, "beat start");
            expAddr = expAddr + step;
        end
    end
    task automatic run(input logic [27:0] a, input logic [1:0] op, pt, sz, input logic rd, am, er,
        input logic [27:0] st, input logic [127:0] wd, input logic [3:0] w, input int nb);
        beats = 0;
        expAddr = a;
        step = st;
        expSize = sz;
        @(posedge clk);
        asyncMode <= am;
        waits <= w;
        req <= '{addr: a, opSize: op, portSize: pt, read: rd, xferType: 2'h1, code: rd, supervisor: !am,
            dram: 1'b0, wdata: wd};
        reqValid <= 1'b1;
        @(posedge clk);
        reqValid <= 1'b0;
        errN <= !er;
        for (lat = 0; lat < 300 && done !== 1'b1; lat++) begin
            @(posedge clk);
            #1;
        end
        check({done, error, pins.dataOe && !rd, reqReady}, {1'b1, er, 1'b0, 1'b1}, "end state");
        check(beats, nb, "beat count");
        @(posedge clk);
        errN <= 1'b1;
    endtask : run
    task automatic t_read8;
        run(28'h130, 2'h0, 2'h1, 2'h1, 1'b1, 1'b0, 1'b0, 28'h1, 128'h0, 4'h0, 4);
        check(rdata[31:0], 32'h0c0d0e0f, "byte lanes");
        $display("done read8");
    endtask : t_read8
    task automatic t_write16;
        run(28'h200, 2'h0, 2'h2, 2'h2, 1'b0, 1'b0, 1'b0, 28'h2, {32'hcafe1234, 96'h0}, 4'h2, 2);
        check(capWords[31:0], 32'hcafe1234, "write words");
        $display("done write16");
    endtask : t_write16
    task automatic t_async_read;
        run(28'h45, 2'h1, 2'h1, 2'h1, 1'b1, 1'b1, 1'b0, 28'h0, 128'h0, 4'h0, 1);
        check({rdata[7:0], lat[3:0]}, {8'h79, 4'h3}, "async read");
        $display("done async read");
    endtask : t_async_read
    // A byte write to a wide port ended by the async answer; the slave captures in the second clock.
    task automatic t_async_write;
        run(28'h80, 2'h1, 2'h0, 2'h1, 1'b0, 1'b1, 1'b0, 28'h0, {8'h5a, 120'h0}, 4'h0, 1);
        check(capWords[15:8], 8'h5a, "async write capture");
        $display("done async write");
    endtask : t_async_write
    // The error is taken while the async answer is still in the synchroniser.
    task automatic t_async_err;
        run(28'h60, 2'h1, 2'h1, 2'h1, 1'b0, 1'b1, 1'b1, 28'h0, {8'ha5, 120'h0}, 4'h0, 1);
        $display("done async error");
    endtask : t_async_err
    task automatic t_line32;
        run(28'h100, 2'h3, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 28'h4, 128'h0, 4'h0, 4);
        check(rdata, {32'h3c3c3c3c, 32'h38383838, 32'h34343434, 32'h30303030}, "line read");
        $display("done line32");
    endtask : t_line32
    task automatic t_dram;
        beats = 0;
        @(posedge clk);
        req.dram <= 1'b1;
        reqValid <= 1'b1;
        repeat (5) @(posedge clk);
        reqValid <= 1'b0;
        req.dram <= 1'b0;
        check(beats, 0, "dram refused");
        check(reqReady, 1'b1, "ready after dram request");
        $display("done dram");
    endtask : t_dram
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // A hung handshake would stall the bench, so a fixed span ends it as a failure.
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
    initial begin
        {sys_rst, errN, reqValid, asyncMode, sawStart, waits, req} = '0;
        sys_rst = 1'b1;
        errN = 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_read8();
        t_write16();
        t_async_read();
        t_async_write();
        t_async_err();
        t_line32();
        t_dram();
        print_verdict();
    end
endmodule : tb
`default_nettype wire
